// File: src/dcm_top.sv
// Signal degrade clearing monitor with byte register port and interrupt
`timescale 1ns/100ps
`default_nettype none

`include "dcm_defines.svh"

module dcm_top
  import dcm_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire dcm_bus_s   bus,
  output logic      [7:0] rdata,
  input  wire dcm_frame_s frame,
  input  wire logic       degrade_declare,
  output logic            signal_degrade,
  output logic            irq_n
);

  // Register state
  logic [7:0]                   control;
  logic [7:0]                   int_mask;
  logic [7:0]                   int_status;
  logic [`DCM_LIMIT_WIDTH-1:0]  degrade_clear_error_limit;
  logic [`DCM_WINDOW_WIDTH-1:0] degrade_clear_window_ms;

  // Register next values
  logic [7:0]                   next_control;
  logic [7:0]                   next_int_mask;
  logic [7:0]                   next_int_status;
  logic [`DCM_LIMIT_WIDTH-1:0]  next_limit;
  logic [`DCM_WINDOW_WIDTH-1:0] next_window;
  logic [7:0]                   next_rdata;

  // Register port events
  logic                         window_written;
  logic                         status_read;

  // Monitor state
  dcm_state_e                   state;
  dcm_state_e                   next_state;
  logic [`DCM_LIMIT_WIDTH-1:0]  err_acc;
  logic [`DCM_LIMIT_WIDTH-1:0]  next_err_acc;

  // Frame error arithmetic
  logic [`DCM_LIMIT_WIDTH:0]    err_sum;
  logic [`DCM_LIMIT_WIDTH-1:0]  err_total;
  logic [`DCM_LIMIT_WIDTH-1:0]  frame_errs;

  // Window and defect events
  logic                         window_restart;
  logic                         unit_tick;
  logic                         window_end;
  logic                         below_limit;
  logic                         declare_event;
  logic                         clear_event;
  logic                         change_event;

  // Frame divider producing the millisecond tick
  dcm_wrap_counter #(
    .WIDTH   (`DCM_DIV_WIDTH)
  ) u_unit_div (
    .clock   (clock),
    .rst     (rst),
    .restart (window_restart),
    .advance (frame.valid),
    .limit   (`DCM_DIV_WIDTH'(`DCM_FRAMES_PER_UNIT)),
    .count   (),
    .wrap    (unit_tick)
  );

  // Millisecond counter marking the end of each window
  dcm_wrap_counter #(
    .WIDTH   (`DCM_WINDOW_WIDTH)
  ) u_window (
    .clock   (clock),
    .rst     (rst),
    .restart (window_restart),
    .advance (unit_tick),
    .limit   (degrade_clear_window_ms),
    .count   (),
    .wrap    (window_end)
  );

  // Errors contributed by this frame
  always_comb begin
    frame_errs = '0;
    if (frame.valid) begin
      if (control[`DCM_CTRL_ERR_TYPE_BIT]) begin
        frame_errs = (frame.bit_errors != 4'h0) ? `DCM_LIMIT_WIDTH'(1) : '0;
      end else begin
        frame_errs = `DCM_LIMIT_WIDTH'(frame.bit_errors);
      end
    end
  end

  // Window restarts on declaration or a new window length
  assign window_restart = degrade_declare || window_written;

  // Software read of the interrupt status register
  assign status_read = bus.rd && (bus.addr == `DCM_ADDR_INT_STATUS);

  // Window total with this frame, held at all ones on overflow
  always_comb begin
    err_sum   = {1'b0, err_acc} + {1'b0, frame_errs};
    err_total = err_sum[`DCM_LIMIT_WIDTH] ? '1 : err_sum[`DCM_LIMIT_WIDTH-1:0];
  end

  // Clearing decision; the frame that closes the window still counts
  assign below_limit   = (err_total < degrade_clear_error_limit);
  assign declare_event = degrade_declare && (state == DCM_ST_CLEAR);
  assign clear_event   = (state == DCM_ST_DECLARED) && window_end && !degrade_declare
                         && below_limit;
  assign change_event  = clear_event || declare_event;

  // Saturating error accumulator, emptied at every window boundary
  always_comb begin
    next_err_acc = err_total;
    if (window_restart || window_end) begin
      next_err_acc = '0;
    end
  end

  // Accumulator register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      err_acc <= '0;
    end else begin
      err_acc <= next_err_acc;
    end
  end

  // Next defect state
  always_comb begin
    next_state = state;
    case (state)
      DCM_ST_CLEAR: begin
        if (degrade_declare) begin
          next_state = DCM_ST_DECLARED;
        end
      end
      DCM_ST_DECLARED: begin
        if (clear_event) begin
          next_state = DCM_ST_CLEAR;
        end
      end
      default: begin
        next_state = DCM_ST_CLEAR;
      end
    endcase
  end

  // Defect state register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= DCM_ST_CLEAR;
    end else begin
      state <= next_state;
    end
  end

  // Configuration writes; each byte lands on its own
  always_comb begin
    next_control   = control;
    next_int_mask  = int_mask;
    next_limit     = degrade_clear_error_limit;
    next_window    = degrade_clear_window_ms;
    window_written = 1'b0;
    if (bus.wr) begin
      case (bus.addr)
        `DCM_ADDR_CONTROL: begin
          next_control = bus.wdata & `DCM_CTRL_WRITE_MASK; // Unused top bit stays zero
        end
        `DCM_ADDR_INT_MASK: begin
          next_int_mask = bus.wdata;
        end
        `DCM_ADDR_LIMIT_HIGH: begin
          next_limit[15:8] = bus.wdata;
        end
        `DCM_ADDR_LIMIT_LOW: begin
          next_limit[7:0] = bus.wdata;
        end
        `DCM_ADDR_WINDOW_TOP: begin
          next_window[23:16] = bus.wdata;
          window_written     = 1'b1;
        end
        `DCM_ADDR_WINDOW_MID: begin
          next_window[15:8] = bus.wdata;
          window_written    = 1'b1;
        end
        `DCM_ADDR_WINDOW_LOW: begin
          next_window[7:0] = bus.wdata;
          window_written   = 1'b1;
        end
        default: begin
          next_control = control; // Unmapped writes are dropped
        end
      endcase
    end
  end

  // Configuration registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      control                   <= `DCM_CONTROL_RESET;
      int_mask                  <= `DCM_INT_MASK_RESET;
      degrade_clear_error_limit <= `DCM_LIMIT_RESET;
      degrade_clear_window_ms   <= `DCM_WINDOW_RESET;
    end else begin
      control                   <= next_control;
      int_mask                  <= next_int_mask;
      degrade_clear_error_limit <= next_limit;
      degrade_clear_window_ms   <= next_window;
    end
  end

  // Interrupt status: a read clears it, a change in the same cycle is kept
  always_comb begin
    next_int_status = int_status;
    if (status_read) begin
      next_int_status = `DCM_BYTE_ZERO;
    end
    if (change_event) begin
      next_int_status[`DCM_INT_DEGRADE_BIT] = 1'b1;
    end
  end

  // Interrupt status register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      int_status <= `DCM_BYTE_ZERO;
    end else begin
      int_status <= next_int_status;
    end
  end

  // Read data for the cycle after the strobe, zero otherwise
  always_comb begin
    next_rdata = `DCM_BYTE_ZERO;
    if (bus.rd) begin
      case (bus.addr)
        `DCM_ADDR_CONTROL: begin
          next_rdata = control;
        end
        `DCM_ADDR_STATUS: begin
          next_rdata = 8'(signal_degrade) << `DCM_STATUS_DEGRADE_BIT;
        end
        `DCM_ADDR_INT_STATUS: begin
          next_rdata = int_status;
        end
        `DCM_ADDR_INT_MASK: begin
          next_rdata = int_mask;
        end
        `DCM_ADDR_LIMIT_HIGH: begin
          next_rdata = degrade_clear_error_limit[15:8];
        end
        `DCM_ADDR_LIMIT_LOW: begin
          next_rdata = degrade_clear_error_limit[7:0];
        end
        `DCM_ADDR_WINDOW_TOP: begin
          next_rdata = degrade_clear_window_ms[23:16];
        end
        `DCM_ADDR_WINDOW_MID: begin
          next_rdata = degrade_clear_window_ms[15:8];
        end
        `DCM_ADDR_WINDOW_LOW: begin
          next_rdata = degrade_clear_window_ms[7:0];
        end
        default: begin
          next_rdata = `DCM_BYTE_ZERO;
        end
      endcase
    end
  end

  // Read data register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata <= `DCM_BYTE_ZERO;
    end else begin
      rdata <= next_rdata;
    end
  end

  // Defect flag straight from the state register
  assign signal_degrade = (state == DCM_ST_DECLARED);

  // Active-low interrupt while an enabled status bit is set
  assign irq_n = ~|(int_status & int_mask);

endmodule : dcm_top

`default_nettype wire

// File: include/dcm_defines.svh
// Register offsets, field positions, reset values and timing for the degrade clearing monitor
`ifndef DCM_DEFINES_SVH
`define DCM_DEFINES_SVH

// Register byte addresses
`define DCM_ADDR_CONTROL        16'h1103
`define DCM_ADDR_STATUS         16'h1107
`define DCM_ADDR_INT_STATUS     16'h110b
`define DCM_ADDR_INT_MASK       16'h110f
`define DCM_ADDR_LIMIT_HIGH     16'h1146
`define DCM_ADDR_LIMIT_LOW      16'h1147
`define DCM_ADDR_WINDOW_TOP     16'h1159
`define DCM_ADDR_WINDOW_MID     16'h115a
`define DCM_ADDR_WINDOW_LOW     16'h115b

// Field positions
`define DCM_CTRL_ERR_TYPE_BIT   1
`define DCM_CTRL_WRITE_MASK     8'h7f
`define DCM_STATUS_DEGRADE_BIT  3
`define DCM_INT_DEGRADE_BIT     6

// Reset values
`define DCM_CONTROL_RESET       8'h00
`define DCM_INT_MASK_RESET      8'hff
`define DCM_LIMIT_RESET         16'hffff
`define DCM_WINDOW_RESET        24'hffffff
`define DCM_BYTE_ZERO           8'h00

// Frame timing: one frame every 125 us, window unit is 1 ms
`define DCM_FRAME_PERIOD_US     125
`define DCM_UNIT_PERIOD_US      1000
`define DCM_FRAMES_PER_UNIT     (`DCM_UNIT_PERIOD_US / `DCM_FRAME_PERIOD_US)
`define DCM_DIV_WIDTH           4
`define DCM_WINDOW_WIDTH        24
`define DCM_LIMIT_WIDTH         16

`endif

// File: include/dcm_pkg.sv
// Types shared by the degrade clearing monitor
package dcm_pkg;

  // Register port request
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } dcm_bus_s;

  // Per-frame parity report from the line overhead checker
  typedef struct packed {
    logic       valid;
    logic [3:0] bit_errors;
  } dcm_frame_s;

  // Degrade defect state
  typedef enum logic {
    DCM_ST_CLEAR,
    DCM_ST_DECLARED
  } dcm_state_e;

endpackage : dcm_pkg

// File: src/dcm_wrap_counter.sv
// Wrapping event counter with programmable length
`timescale 1ns/100ps
`default_nettype none

module dcm_wrap_counter #(
  parameter int WIDTH = 4
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             restart,
  input  wire logic             advance,
  input  wire logic [WIDTH-1:0] limit,
  output logic      [WIDTH-1:0] count,
  output logic                  wrap
);

  logic [WIDTH-1:0] next_count;
  logic [WIDTH-1:0] count_plus;

  // Wrap when the advanced count reaches the limit; a zero limit never wraps
  always_comb begin
    count_plus = count + {{(WIDTH-1){1'b0}}, 1'b1};
    wrap       = advance && !restart && (limit != '0) && (count_plus == limit);
    next_count = count;
    if (restart || wrap) begin
      next_count = '0;
    end else if (advance) begin
      next_count = count_plus;
    end
  end

  // Count register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

endmodule : dcm_wrap_counter

`default_nettype wire

// File: sim/dcm_checker.sv
// Port checks for the degrade clearing monitor
`timescale 1ns/100ps
`default_nettype none
`include "dcm_defines.svh"
module dcm_checker
  import dcm_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst,
  input wire dcm_bus_s   bus,
  input wire logic [7:0] rdata,
  input wire dcm_frame_s frame,
  input wire logic       degrade_declare,
  input wire logic       signal_degrade,
  input wire logic       irq_n
);
  default clocking dcb @(posedge clock); endclocking
  default disable iff (rst);
  // Register port, defect and interrupt relations
  chk_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 8'h00)
    else $error("read data outside its slot");
  chk_status_bit: assert property ($past(bus.rd) && $past(bus.addr) == `DCM_ADDR_STATUS
    |-> rdata == {4'h0, $past(signal_degrade), 3'h0}) else $error("status read wrong");
  chk_declare_sets: assert property (degrade_declare |=> signal_degrade)
    else $error("declare not seen");
  chk_stays_clear: assert property (!degrade_declare && !signal_degrade |=> !signal_degrade)
    else $error("degrade rose without declare");
  chk_clear_on_frame: assert property ($fell(signal_degrade) |-> $past(frame.valid))
    else $error("clear off a frame edge");
  chk_clear_irq: assert property ($fell(signal_degrade) |-> !irq_n)
    else $error("clear without interrupt");
  chk_irq_cause: assert property ($fell(irq_n) |-> $past(degrade_declare) || $fell(signal_degrade))
    else $error("interrupt without cause");
  chk_read_release: assert property (bus.rd && bus.addr == `DCM_ADDR_INT_STATUS
    && !degrade_declare && !frame.valid |=> irq_n) else $error("read did not release");
  chk_int_bit: assert property ($past(bus.rd) && $past(bus.addr) == `DCM_ADDR_INT_STATUS
    && !$past(irq_n) |-> rdata[6]) else $error("status bit 6 missing");
endmodule : dcm_checker
`default_nettype wire

// File: sim/dcm_line_model.sv
// Far terminal: one parity report every GAP cycles
`timescale 1ns/100ps
`default_nettype none
module dcm_line_model
  import dcm_pkg::*;
#(
  parameter int GAP = 16
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [3:0] errs,
  output var  dcm_frame_s frame
);
  int cnt;
  // Frame pulse; error field scrambled between frames
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt   <= 0;
      frame <= '0;
    end else begin
      cnt              <= (cnt == GAP - 1) ? 0 : cnt + 1;
      frame.valid      <= (cnt == GAP - 1);
      frame.bit_errors <= (cnt == GAP - 1) ? errs : ~frame.bit_errors;
    end
  end
endmodule : dcm_line_model
`default_nettype wire

// File: sim/testbench.sv
// Self-checking bench for the degrade clearing monitor
`timescale 1ns/100ps
`default_nettype none
`include "dcm_defines.svh"
module testbench
  import dcm_pkg::*;
;
  logic       clock;
  logic       rst;
  dcm_bus_s   bus;
  logic [7:0] rdata;
  dcm_frame_s frame;
  logic       degrade_declare;
  logic       signal_degrade;
  logic       irq_n;
  logic [3:0] errs;
  int         mismatches;
  int         total_checks;

  dcm_top uut (.clock(clock), .rst(rst), .bus(bus), .rdata(rdata), .frame(frame),
    .degrade_declare(degrade_declare), .signal_degrade(signal_degrade), .irq_n(irq_n));
  dcm_line_model far (.clock(clock), .rst(rst), .errs(errs), .frame(frame));

  // Clock
  always #10 clock = ~clock;

  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : cmp

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clock);
    bus.wr <= 1'b0;
    @(posedge clock);
  endtask : wr

  // Read, then compare data in the following cycle
  task automatic rc(input logic [15:0] a, input logic [7:0] e);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clock);
    bus.rd <= 1'b0;
    @(posedge clock);
    cmp($sformatf("reg %h", a), e, rdata);
  endtask : rc

  task automatic frames(input int n);
    repeat (n) begin
      @(posedge clock);
      while (frame.valid !== 1'b1) @(posedge clock);
    end
  endtask : frames

  task automatic reg_case;
    rc(`DCM_ADDR_LIMIT_HIGH, 8'hff);
    rc(`DCM_ADDR_LIMIT_LOW, 8'hff);
    rc(`DCM_ADDR_WINDOW_MID, 8'hff);
    rc(`DCM_ADDR_STATUS, 8'h00);
    wr(16'h1150, 8'h5a);
    rc(16'h1150, 8'h00);
    wr(`DCM_ADDR_WINDOW_TOP, 8'h00);
    wr(`DCM_ADDR_WINDOW_MID, 8'h00);
    wr(`DCM_ADDR_WINDOW_LOW, 8'h01);
    wr(`DCM_ADDR_LIMIT_HIGH, 8'h00);
    wr(`DCM_ADDR_LIMIT_LOW, 8'h09);
    rc(`DCM_ADDR_WINDOW_TOP, 8'h00);
    rc(`DCM_ADDR_WINDOW_LOW, 8'h01);
    rc(`DCM_ADDR_LIMIT_LOW, 8'h09);
    rc(`DCM_ADDR_INT_MASK, 8'hff);
    wr(`DCM_ADDR_CONTROL, 8'hff);
    rc(`DCM_ADDR_CONTROL, 8'h7f);
    $display("register case done");
  endtask : reg_case

  // Declare, run one 1 ms window of 8 frames, expect clear or hold; st is the status after declaring
  task automatic window_case(input logic [7:0] ctl, input logic [3:0] e, input logic keep,
                             input logic [7:0] st);
    errs <= e;
    wr(`DCM_ADDR_CONTROL, ctl);
    frames(1);
    degrade_declare <= 1'b1;
    @(posedge clock);
    degrade_declare <= 1'b0;
    rc(`DCM_ADDR_INT_STATUS, st);
    frames(7);
    @(posedge clock);
    cmp("degrade mid", 8'h01, {7'h0, signal_degrade});
    frames(1);
    @(posedge clock);
    cmp("degrade end", {7'h0, keep}, {7'h0, signal_degrade});
    cmp("irq_n end", {7'h0, keep}, {7'h0, irq_n});
    if (!keep) rc(`DCM_ADDR_INT_STATUS, 8'h40);
    cmp("irq_n read", 8'h01, {7'h0, irq_n});
    $display("window case done");
  endtask : window_case

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop

  // Main sequence
  initial begin
    clock = 1'b0;
    rst = 1'b1;
    bus = '0;
    degrade_declare = 1'b0;
    errs = 4'h0;
    mismatches = 0;
    total_checks = 0;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    reg_case;
    window_case(8'h00, 4'h1, 1'b0, 8'h40);
    window_case(8'h02, 4'h2, 1'b0, 8'h40);
    window_case(8'h00, 4'h2, 1'b1, 8'h40);
    wr(`DCM_ADDR_LIMIT_LOW, 8'h08);
    window_case(8'h00, 4'h1, 1'b1, 8'h00);
    report_and_stop;
  end

  // Watchdog
  initial begin
    #100000;
    mismatches++;
    report_and_stop;
  end
endmodule : testbench

bind dcm_top dcm_checker chk (.clock(clock), .rst(rst), .bus(bus), .rdata(rdata), .frame(frame),
  .degrade_declare(degrade_declare), .signal_degrade(signal_degrade), .irq_n(irq_n));
`default_nettype wire
